// [hdl/watchdog_timer_8bit.v]
`timescale 1ns/1ns
`include "watchdog_regs.vh"
module watchdog_timer_8bit (
	input  wire        mclk,
	input  wire        rst,
	input  wire        clk_en,
	input  wire        main_oscillator_input,
	input  wire        sub_oscillator_input,
	input  wire        onchip_osc_input,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         internal_reset,
	output reg         stop_mode,
	output reg         idle_mode,
	output reg         onchip_osc_force
);

// ==========================================
// Pin synchronisers
reg [2:0] src_s1_reg;
reg [2:0] src_s2_reg;
reg [2:0] src_d_reg;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		src_s1_reg <= 3'h0;
		src_s2_reg <= 3'h0;
		src_d_reg  <= 3'h0;
	end else if (clk_en) begin
		src_s1_reg <= {onchip_osc_input, sub_oscillator_input, main_oscillator_input};
		src_s2_reg <= src_s1_reg;
		src_d_reg  <= src_s2_reg;
	end
end

// ==========================================
// Decode and arithmetic helpers
// One decoder serves the strobes and the read mux so both see the same map
function is_ctrl_addr(input [11:0] addr);
	is_ctrl_addr = (addr == `WDT_CONTROL_ADDR);
endfunction

function is_status_addr(input [11:0] addr);
	is_status_addr = (addr == `WDT_STATUS_ADDR);
endfunction

function is_cmd_addr(input [11:0] addr);
	is_cmd_addr = (addr == `WDT_CMD_ADDR);
endfunction

function [7:0] dec8(input [7:0] value);
	dec8 = value - 8'h01;
endfunction

function [31:0] ctrl_word(input [2:0] ctrl, input [7:0] count);
	// Selects on top, the five high counter bits below
	ctrl_word = {24'h000000, ctrl, count[7:3]};
endfunction

function [31:0] status_word(input lock, input run, input idle, input halt, input rst_out);
	status_word = {24'h000000, 3'h0, lock, run, idle, halt, rst_out};
endfunction

// ==========================================
// State
reg  [7:0]  count_reg;
reg  [7:0]  count_next;
reg  [2:0]  ctrl_reg;
reg  [2:0]  ctrl_next;
reg         locked_reg;
reg         locked_next;
reg         running_reg;
reg         running_next;
reg  [9:0]  pre_reg;
reg  [9:0]  pre_next;
reg  [7:0]  hold_reg;
reg  [7:0]  hold_next;
reg         internal_reset_next;
reg         stop_next;
reg         idle_next;
reg  [31:0] prdata_next;
reg         pready_next;
reg         pslverr_next;

// ==========================================
// Bus strobes
wire       bus_access = psel & penable & pready;
wire       wr_ctrl    = bus_access & pwrite & is_ctrl_addr(paddr);
wire       wr_cmd     = bus_access & pwrite & is_cmd_addr(paddr);
wire       halt_cmd   = wr_cmd & pwdata[`WDT_CMD_HALT_BIT];
wire       idle_cmd   = wr_cmd & pwdata[`WDT_CMD_IDLE_BIT];
wire       wake_cmd   = wr_cmd & pwdata[`WDT_CMD_WAKE_BIT];

// ==========================================
// Count source and prescaler
wire       sel        = ctrl_reg[2];
wire       halt_fn    = ctrl_reg[1];
wire       sel2       = ctrl_reg[0];
wire       in_hold    = (hold_reg != 8'h00);
// Edge of the selected count source; on-chip source overrides the oscillator pair
wire [2:0] src_rise   = src_s2_reg & ~src_d_reg;
wire       src_tick   = sel2 ? src_rise[2] : (stop_mode ? 1'b0 : (src_rise[0] | src_rise[1]));
wire [9:0] pre_top    = sel ? {6'h0, `WDT_PRESCALE_HIGH} : `WDT_PRESCALE_LOW;
wire       pre_wrap   = src_tick & (pre_reg == pre_top);
wire       underflow  = running_reg & pre_wrap & (count_reg == 8'h00);
wire       halt_reset = halt_cmd & halt_fn;

// ==========================================
// Counter and prescaler next state
always @* begin
	count_next = count_reg;
	pre_next   = pre_reg;
	if (in_hold) begin
		// Internal reset returns the counter to its reset value
		count_next = `WDT_COUNT_RESET;
		pre_next   = 10'h000;
	end else if (wr_ctrl) begin
		// The data written plays no part in the reload
		count_next = `WDT_COUNT_RESET;
		pre_next   = 10'h000;
	end else if (running_reg & src_tick) begin
		// Keeps counting in idle, and in stop mode only from the on-chip source
		if (pre_wrap) begin
			pre_next   = 10'h000;
			count_next = dec8(count_reg);
		end else begin
			pre_next = pre_reg + 10'h001;
		end
	end
end

// ==========================================
// Control bits next state
always @* begin
	ctrl_next    = ctrl_reg;
	locked_next  = locked_reg;
	running_next = running_reg;
	if (in_hold) begin
		ctrl_next    = `WDT_CTRL_RESET;
		locked_next  = 1'b0;
		running_next = 1'b0;
	end else if (wr_ctrl) begin
		running_next = 1'b1;
		// Only the first write after reset reaches the selects; later ones just reload
		if (!locked_reg) begin
			ctrl_next   = {pwdata[`WDT_SEL_BIT], pwdata[`WDT_HALT_FN_BIT],
				pwdata[`WDT_SEL2_BIT]};
			locked_next = 1'b1;
		end
	end
end

// ==========================================
// Internal reset hold next state
always @* begin
	hold_next = hold_reg;
	if (underflow | halt_reset) begin
		hold_next = `WDT_RESET_HOLD;
	end else if (in_hold) begin
		hold_next = dec8(hold_reg);
	end
	// The output covers the trigger cycle and all but the last hold cycle
	internal_reset_next = underflow | halt_reset | (hold_reg > 8'h01);
end

// ==========================================
// Stop and idle modes next state
always @* begin
	stop_next = stop_mode;
	idle_next = idle_mode;
	if (in_hold) begin
		stop_next = 1'b0;
		idle_next = 1'b0;
	end else if (wake_cmd) begin
		// Release lets counting go on from where the counter stood
		stop_next = 1'b0;
		idle_next = 1'b0;
	end else begin
		if (halt_cmd & !halt_fn) begin
			stop_next = 1'b1;
		end
		if (idle_cmd) begin
			idle_next = 1'b1;
		end
	end
end

// ==========================================
// APB slave next state, zero wait states
// Read data is captured in the setup cycle so it stands through the access cycle
always @* begin
	pready_next  = 1'b0;
	pslverr_next = 1'b0;
	prdata_next  = prdata;
	if (psel & !penable) begin
		pready_next = 1'b1;
		prdata_next = 32'h00000000;
		if (is_ctrl_addr(paddr)) begin
			prdata_next = ctrl_word(ctrl_reg, count_reg);
		end else if (is_status_addr(paddr)) begin
			prdata_next = status_word(locked_reg, running_reg, idle_mode, stop_mode,
				internal_reset);
		end else if (is_cmd_addr(paddr)) begin
			prdata_next = 32'h00000000;
		end else begin
			// Unmapped offsets answer with an error and read as zero
			pslverr_next = 1'b1;
		end
	end
end

// ==========================================
// Counter and prescaler registers
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		count_reg <= `WDT_COUNT_RESET;
	end else if (clk_en) begin
		count_reg <= count_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		pre_reg <= 10'h000;
	end else if (clk_en) begin
		pre_reg <= pre_next;
	end
end

// ==========================================
// Control registers
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		ctrl_reg <= `WDT_CTRL_RESET;
	end else if (clk_en) begin
		ctrl_reg <= ctrl_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		locked_reg <= 1'b0;
	end else if (clk_en) begin
		locked_reg <= locked_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		running_reg <= 1'b0;
	end else if (clk_en) begin
		running_reg <= running_next;
	end
end

// ==========================================
// Internal reset registers
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		hold_reg <= 8'h00;
	end else if (clk_en) begin
		hold_reg <= hold_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		internal_reset <= 1'b0;
	end else if (clk_en) begin
		internal_reset <= internal_reset_next;
	end
end

// ==========================================
// Mode registers
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		stop_mode <= 1'b0;
	end else if (clk_en) begin
		stop_mode <= stop_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		idle_mode <= 1'b0;
	end else if (clk_en) begin
		idle_mode <= idle_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		onchip_osc_force <= 1'b0;
	end else if (clk_en) begin
		// Forced on while selected; stop mode cannot gate it off
		onchip_osc_force <= sel2;
	end
end

// ==========================================
// APB slave registers
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		prdata <= 32'h00000000;
	end else if (clk_en) begin
		prdata <= prdata_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		pready <= 1'b0;
	end else if (clk_en) begin
		pready <= pready_next;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		pslverr <= 1'b0;
	end else if (clk_en) begin
		pslverr <= pslverr_next;
	end
end

endmodule

// [hdl/watchdog_regs.vh]
`ifndef WATCHDOG_REGS_VH
`define WATCHDOG_REGS_VH
// ==========================================
// Register map
`define WDT_CONTROL_ADDR     12'h000
`define WDT_STATUS_ADDR      12'h004
`define WDT_CMD_ADDR         12'h008
// Control register fields
`define WDT_SEL_BIT          7
`define WDT_HALT_FN_BIT      6
`define WDT_SEL2_BIT         5
`define WDT_CTRL_RESET       3'h0
`define WDT_COUNT_RESET      8'hff
// Command register fields
`define WDT_CMD_HALT_BIT     0
`define WDT_CMD_IDLE_BIT     1
`define WDT_CMD_WAKE_BIT     2
// ==========================================
// Timing
`define WDT_PRESCALE_LOW     10'h3ff
`define WDT_PRESCALE_HIGH    4'hf
`define WDT_RESET_HOLD       8'h10
`endif

// [dv/watchdog_checker.sv]
`timescale 1ns/1ns
module watchdog_checker (
	input wire        mclk,
	input wire        rst,
	input wire        clk_en,
	input wire        main_oscillator_input,
	input wire        sub_oscillator_input,
	input wire        onchip_osc_input,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        internal_reset,
	input wire        stop_mode,
	input wire        idle_mode,
	input wire        onchip_osc_force
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ====
	// Armed once software has reloaded; a watchdog reset disarms it again
	reg  started_reg;
	wire cw = psel && penable && pready && pwrite && paddr == 12'h000;
	wire cmd = psel && penable && pready && pwrite && paddr == 12'h008;
	always @(posedge mclk or posedge rst)
		if (rst) started_reg <= 1'b0;
		else if (internal_reset) started_reg <= 1'b0;
		else if (cw) started_reg <= 1'b1;
	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("ready");
	ready_once_a: assert property (pready |=> !pready) else $error("ready held");
	reset_hold_a: assert property ($rose(internal_reset) |=> internal_reset[*8])
		else $error("reset short");
	force_read_a: assert property (pready && !pwrite && paddr == 12'h000
		|-> prdata[5] == onchip_osc_force) else $error("force");
	bad_addr_a: assert property (pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0)
		else $error("unmapped");
	halt_cmd_a: assert property (cmd && pwdata[0] |-> ##[1:3] (stop_mode || internal_reset))
		else $error("halt");
	idle_cmd_a: assert property (cmd && pwdata[1] |-> ##[1:3] idle_mode) else $error("idle");
	unarmed_quiet_a: assert property (!started_reg && !internal_reset |=> !internal_reset)
		else $error("reset unarmed");
	cover property ($rose(internal_reset));
	cover property (stop_mode);
	cover property (idle_mode);
endmodule
bind watchdog_timer_8bit watchdog_checker chk_u (.*);

// [dv/watchdog_timer_8bit_tb.sv]
`timescale 1ns/1ns
module watchdog_timer_8bit_tb;
	reg        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, mo = 0, so = 0, er;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	wire[31:0] prdata;
	wire       pready, pslverr, irst, halt_oscillator_instruction, idl, frc;
	int        fail_count = 0, n_tests = 0, k;
	watchdog_timer_8bit dut_u (.mclk(mclk), .rst(rst), .clk_en(1'b1), .main_oscillator_input(mo),
		.sub_oscillator_input(so), .onchip_osc_input(1'b0), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .internal_reset(irst), .stop_mode(halt_oscillator_instruction), .idle_mode(idl),
		.onchip_osc_force(frc));
	initial forever #20 mclk = ~mclk;
	// ====
	// Bus, source and compare helpers
	task ck(input string n, input [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task ap(input w, input [11:0] a, input [31:0] d);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk) penable <= 1;
		do @(posedge mclk); while (!pready);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task rc(input [31:0] e); ap(0, 0, 0); ck("ctl", rd, e); endtask
	// Edges are spaced 8 cycles, well under the synchroniser limit
	task ed(input int n, input int w = 0);
		repeat (2 * n) begin
			repeat (4) @(posedge mclk);
			if (w) so <= ~so;
			else mo <= ~mo;
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task t_lock;
		rc(32'h1f);
		ed(40);
		rc(32'h1f);
		ap(1, 0, 32'h80);
		ap(1, 0, 32'h60);
		rc(32'h9f);
	endtask
	// 168 edges give ten steps at the fast prescale
	task t_modes;
		ap(1, 8, 2);
		@(negedge mclk) ck("idle", idl, 1);
		ap(0, 4, 0);
		ck("status", rd, 32'h1c);
		ed(168);
		rc(32'h9e);
		ap(1, 8, 4);
		ap(1, 0, 0);
		ap(1, 8, 1);
		@(negedge mclk) ck("stop", halt_oscillator_instruction, 1);
		ed(168);
		rc(32'h9f);
		ap(1, 8, 4);
		ed(168, 1);
		rc(32'h9e);
		ap(0, 12'h00c, 0);
		ck("err", er, 1);
		ck("err rd", rd, 0);
	endtask
	task t_under;
		ap(1, 0, 0);
		for (k = 0; !irst && k < 5000; k++) ed(1);
		ck("edges", k >= 4080 && k <= 4104, 1);
		repeat (20) @(posedge mclk);
		rc(32'h1f);
	endtask
	task t_halt;
		ap(1, 0, 32'h60);
		repeat (2) @(negedge mclk);
		ck("force", frc, 1);
		ed(168);
		rc(32'h7f);
		ap(1, 8, 1);
		repeat (3) @(negedge mclk);
		ck("rst", {irst, halt_oscillator_instruction}, 2'b10);
		repeat (20) @(posedge mclk);
		rc(32'h1f);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 0;
		t_lock;
		t_modes;
		t_under;
		t_halt;
		summarize;
	end
	initial begin
		#2000000;
		fail_count++;
		summarize;
	end
endmodule
